// [core/dbu_cfg.svh]
// Purpose: constants of the data buffer unit (offsets, fields, resets, sizes)
// Assumes: included by the design file and the testbench
// Notes:   all values are `define macros; types live in dbu_pkg
//
// Functional notes
// RULE1: prefetch buffer: four 64-bit columns, four valid bits
// RULE2: prefetch miss bursts four doublewords, forwards requested one
// RULE3: prefetch hit answers from buffer, no memory access
// RULE4: uncached fetch bypasses, invalidates matching prefetch entry
// RULE5: memory exception clears prefetch valid bits
// RULE6: only spaces 8,9 prefetch; doubleword loads count
// RULE7: atomic hitting prefetch buffer invalidates, goes uncached
// RULE8: flush instruction empties prefetch buffer
// RULE9: two line buffers, four columns, own tag/valid
// RULE10: replacement picks least recently used line buffer
// RULE11: load hitting line buffer answers from it
// RULE12: cached load miss bursts four, forwards first immediately
// RULE13: uncached load bypasses, invalidates matching line buffer
// RULE14: atomics uncached in line buffers and store fifo
// RULE15: store fifo 64-bit, 16 or 6 deep, single writes
// RULE16: merge sub-doubleword store into newest matching entry
// RULE17: per-byte valid bits drive write byte enables
// RULE18: buffer accesses served strictly in program order
// RULE19: atomic: drain fifo, read, invalidate, then write (the unit invalidates when it takes the atomic, before the drain)
// RULE20: cached store always queues, merges only newest entry
// RULE21: load missing buffers but hitting fifo drains first
// RULE22: load hitting both drains, updates buffer, answers single
`ifndef DBU_CFG_SVH
`define DBU_CFG_SVH
// ===========================================
// register map
`define DBU_REG_CTRL        8'h00
`define DBU_REG_STATUS      8'h04
`define DBU_CTRL_MERGE_BIT  0
`define DBU_CTRL_SHORT_BIT  1
`define DBU_CTRL_RESET      2'h1
`define DBU_ST_CNT_LSB      0
`define DBU_ST_IBV_LSB      5
`define DBU_ST_RBV_LSB      9
`define DBU_ST_BUSY_BIT     11
// ===========================================
// sizes and encodings
`define DBU_FIFO_DEPTH      16
`define DBU_FIFO_SHORT      6
`define DBU_COLS            4
`define DBU_ASI_INSTR_A     4'h8
`define DBU_ASI_INSTR_B     4'h9
`define DBU_ASI_DATA_A      4'ha
`define DBU_ASI_DATA_B      4'hb
`define DBU_BE_FULL         8'hff
`endif

// [core/dbu_pkg.sv]
// Purpose: types of the data buffer unit
// Assumes: dbu_cfg.svh for sizes
// Notes:   request and memory command travel as packed structs
package dbu_pkg;
   // ===========================================
   // request kinds from the internal core bus
   typedef enum logic [2:0] {
      DBU_FETCH  = 3'h0,   // instruction fetch
      DBU_LOAD   = 3'h1,   // data load
      DBU_STORE  = 3'h2,   // data store
      DBU_ATOMIC = 3'h3,   // atomic load-store
      DBU_FLUSH  = 3'h4    // flush instruction
   } dbu_kind_t;
   // core request
   typedef struct packed {
      dbu_kind_t   kind;   // access kind
      logic [3:0]  asi;    // address space identifier
      logic        nc;     // non-cache area flag
      logic [31:0] addr;   // byte address
      logic [7:0]  be;     // byte lanes (size)
      logic [63:0] wdata;  // store data
   } dbu_req_t;
   // memory command
   typedef struct packed {
      logic        we;     // write
      logic        burst;  // four-beat read
      logic [31:0] addr;   // doubleword-aligned address
      logic [7:0]  be;     // byte enables
      logic [63:0] wdata;  // write data
   } dbu_mem_t;
   // controller states
   typedef enum logic [2:0] {
      DBU_S_IDLE  = 3'h0,  // take a request or drain in background
      DBU_S_DRAIN = 3'h1,  // empty the store fifo first
      DBU_S_RD    = 3'h2,  // issue read
      DBU_S_RDAT  = 3'h3,  // collect read beats
      DBU_S_AWR   = 3'h4   // atomic store half
   } dbu_state_t;
endpackage

// [core/dbu_data_buffer_unit.sv]
// Purpose: data buffer unit: prefetch buffer, two line buffers, store fifo
// Assumes: one outstanding core request; memory grants with mem_gnt, read
//          beats on mem_rvalid in wrap order from the requested column
// Notes:   fifo depth select should change only while the fifo is empty
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dbu_cfg.svh"
module dbu_data_buffer_unit (
   input  wire logic             ref_clk,     // 40 MHz clock
   input  wire logic             rstn,        // sync reset, low
   input  wire dbu_pkg::dbu_req_t req,        // core request
   input  wire logic             req_valid,   // request present
   output logic                  req_ready,   // request taken
   output logic                  rsp_valid,   // answer pulse
   output logic [63:0]           rsp_data,    // answer doubleword
   input  wire logic             mem_exc,     // memory exception level
   output dbu_pkg::dbu_mem_t     mem_cmd,     // memory command
   output logic                  mem_req,     // command valid
   input  wire logic             mem_gnt,     // command accepted
   input  wire logic             mem_rvalid,  // read beat
   input  wire logic [63:0]      mem_rdata,   // read beat data
   input  wire logic [7:0]       reg_addr,    // register address
   input  wire logic [31:0]      reg_wdata,   // register write data
   input  wire logic             reg_wr,      // write strobe
   input  wire logic             reg_rd,      // read strobe
   output logic [31:0]           reg_rdata    // read data, next cycle
);
   import dbu_pkg::*;
   localparam int D = `DBU_FIFO_DEPTH;
   // ===========================================
   // storage
   logic [26:0]  ib_tag_q;                    // prefetch tag
   logic [3:0]   ib_valid_q;                  // per-column valid
   logic [63:0]  ib_data_q [4];               // prefetch columns
   logic [26:0]  rb_tag_q  [2];               // line buffer tags
   logic [1:0]   rb_valid_q;                  // line buffer valid
   logic [63:0]  rb_data_q [2][4];            // line buffer columns
   logic         lru_q;                       // least recently used
   logic [28:0]  sf_addr_q [D];               // fifo doubleword address
   logic [63:0]  sf_data_q [D];               // fifo data
   logic [7:0]   sf_be_q   [D];               // fifo byte valid
   logic [D-1:0] sf_occ_q;                    // occupied entries
   logic [3:0]   wr_ptr_q, rd_ptr_q;          // fifo pointers
   logic [4:0]   cnt_q;                       // fifo fill
   logic [1:0]   ctrl_q;                      // merge / short depth
   dbu_state_t   state_q;                     // controller state
   dbu_req_t     pend_q;                      // request in service
   logic         p_burst_q, p_tgt_rb_q;       // burst / fills line buffer
   logic         p_sel_q, p_rbans_q;          // line buffer / answer from it
   logic         p_noread_q;                  // drain only
   logic [1:0]   beat_q;                      // beat count
   // ===========================================
   // request decode
   logic        take, is_ibk, cach, ib_hit, sf_hit, full, merge;
   logic [1:0]  rb_hit;
   logic [26:0] rtag;
   logic [1:0]  rcol;
   logic [3:0]  depth, last, rd_sel;
   logic [D-1:0] hit_vec;
   assign rtag   = req.addr[31:5];
   assign rcol   = req.addr[4:3];
   assign depth  = ctrl_q[`DBU_CTRL_SHORT_BIT] ? 4'(`DBU_FIFO_SHORT - 1) : 4'(D - 1);
   assign last   = (wr_ptr_q == 4'h0) ? (ctrl_q[`DBU_CTRL_SHORT_BIT] ? 4'(`DBU_FIFO_SHORT - 1) : 4'(D - 1))
                                      : wr_ptr_q - 4'h1;
   assign rd_sel = !mem_req ? rd_ptr_q : (rd_ptr_q == depth) ? 4'h0 : rd_ptr_q + 4'h1; // next to send
   // prefetch side: fetches and doubleword loads to spaces 8, 9
   assign is_ibk = (req.asi == `DBU_ASI_INSTR_A || req.asi == `DBU_ASI_INSTR_B) &&
                   (req.kind == DBU_FETCH || (req.kind == DBU_LOAD && req.be == `DBU_BE_FULL)); // RULE6
   assign cach   = !req.nc && (is_ibk || req.asi == `DBU_ASI_DATA_A || req.asi == `DBU_ASI_DATA_B);
   assign ib_hit = ib_tag_q == rtag && ib_valid_q[rcol];
   // per-entry fifo address compare
   genvar gi;
   generate
      for (gi = 0; gi < D; gi++) begin : g_hit
         assign hit_vec[gi] = sf_occ_q[gi] && sf_addr_q[gi] == req.addr[31:3];
      end
      for (gi = 0; gi < 2; gi++) begin : g_rb
         assign rb_hit[gi] = rb_valid_q[gi] && rb_tag_q[gi] == rtag; // RULE9
      end
   endgenerate
   assign sf_hit = |hit_vec;
   assign full   = cnt_q == 5'(depth) + 5'h1;
   // merge only into the newest entry, sub-doubleword stores
   assign merge  = ctrl_q[`DBU_CTRL_MERGE_BIT] && cnt_q != 5'h0 && req.be != `DBU_BE_FULL &&
                   sf_addr_q[last] == req.addr[31:3]; // RULE16 RULE20
   // one request at a time keeps program order
   assign req_ready = state_q == DBU_S_IDLE && !mem_req &&
                      !(req.kind == DBU_STORE && full && !merge); // RULE18
   assign take = req_valid && req_ready;
   // ===========================================
   // controller
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_q    <= DBU_S_IDLE;
         pend_q     <= '0;
         p_burst_q  <= 1'b0;
         p_tgt_rb_q <= 1'b0;
         p_sel_q    <= 1'b0;
         p_rbans_q  <= 1'b0;
         p_noread_q <= 1'b0;
         beat_q     <= 2'h0;
         mem_req    <= 1'b0;
         mem_cmd    <= '0;
         rsp_valid  <= 1'b0;
         rsp_data   <= 64'h0;
      end else begin
         rsp_valid <= 1'b0;
         if (mem_req && mem_gnt) begin
            mem_req <= 1'b0;
         end
         case (state_q)
            DBU_S_IDLE: begin
               if (take) begin
                  pend_q     <= req;
                  p_burst_q  <= 1'b0;
                  p_rbans_q  <= 1'b0;
                  p_noread_q <= 1'b0;
                  p_tgt_rb_q <= !is_ibk;
                  p_sel_q    <= lru_q; // RULE10
                  case (req.kind)
                     DBU_FLUSH, DBU_STORE: begin
                        rsp_valid <= 1'b1;
                        // uncached store is pushed then written out at once
                        if (req.kind == DBU_STORE && !(cach && !is_ibk)) begin
                           p_noread_q <= 1'b1;
                           state_q    <= DBU_S_DRAIN;
                        end
                     end
                     DBU_ATOMIC: begin
                        state_q <= DBU_S_DRAIN; // RULE14 RULE19
                     end
                     default: begin
                        if (!cach) begin
                           state_q <= DBU_S_DRAIN; // RULE4 RULE13
                        end else if (is_ibk) begin
                           if (ib_hit) begin
                              rsp_valid <= 1'b1;
                              rsp_data  <= ib_data_q[rcol]; // RULE3
                           end else begin
                              p_burst_q <= 1'b1;
                              state_q   <= DBU_S_RD; // RULE2
                           end
                        end else if (sf_hit) begin
                           // fifo holds newer data: write it out first
                           p_burst_q <= ~|rb_hit; // RULE21
                           p_rbans_q <= |rb_hit; // RULE22
                           p_sel_q   <= rb_hit[1] ? 1'b1 : (rb_hit[0] ? 1'b0 : lru_q);
                           state_q   <= DBU_S_DRAIN;
                        end else if (|rb_hit) begin
                           rsp_valid <= 1'b1;
                           rsp_data  <= rb_data_q[rb_hit[1]][rcol]; // RULE11
                        end else begin
                           p_burst_q <= 1'b1;
                           state_q   <= DBU_S_RD; // RULE12
                        end
                     end
                  endcase
               end else if (cnt_q != 5'h0 && !mem_req) begin
                  state_q    <= DBU_S_DRAIN;
                  p_noread_q <= 1'b1;
                  pend_q     <= '0;
               end
            end
            DBU_S_DRAIN: begin
               // single, non-burst writes from the head entry
               if (!mem_req || mem_gnt) begin
                  if (cnt_q == 5'h0 || (cnt_q == 5'h1 && mem_req)) begin
                     if (p_noread_q) begin
                        state_q <= DBU_S_IDLE;
                     end else if (p_rbans_q) begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= rb_data_q[p_sel_q][pend_q.addr[4:3]]; // RULE22
                        state_q   <= DBU_S_IDLE;
                     end else begin
                        state_q <= DBU_S_RD;
                     end
                  end else begin
                     mem_req <= 1'b1;
                     mem_cmd <= '{we: 1'b1, burst: 1'b0, addr: {sf_addr_q[rd_sel], 3'h0},
                                 be: sf_be_q[rd_sel],
                                 wdata: sf_data_q[rd_sel]}; // RULE15 RULE17
                  end
               end
            end
            DBU_S_RD: begin
               mem_req <= 1'b1;
               mem_cmd <= '{we: 1'b0, burst: p_burst_q, addr: {pend_q.addr[31:3], 3'h0},
                           be: p_burst_q ? `DBU_BE_FULL : pend_q.be, wdata: 64'h0};
               beat_q  <= 2'h0;
               state_q <= DBU_S_RDAT;
            end
            DBU_S_RDAT: begin
               if (mem_rvalid) begin
                  beat_q <= beat_q + 2'h1;
                  if (beat_q == 2'h0) begin
                     rsp_valid <= 1'b1;
                     rsp_data  <= mem_rdata; // RULE2 RULE12
                  end
                  if (!p_burst_q) begin
                     state_q <= (pend_q.kind == DBU_ATOMIC) ? DBU_S_AWR : DBU_S_IDLE;
                  end else if (beat_q == 2'h3) begin
                     state_q <= DBU_S_IDLE;
                  end
               end
            end
            DBU_S_AWR: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_cmd <= '{we: 1'b1, burst: 1'b0, addr: {pend_q.addr[31:3], 3'h0},
                              be: pend_q.be, wdata: pend_q.wdata}; // RULE19
               end else if (mem_gnt) begin
                  state_q <= DBU_S_IDLE;
               end
            end
            default: begin
               state_q <= DBU_S_IDLE;
            end
         endcase
      end
   end
   // ===========================================
   // prefetch buffer
   logic [1:0] fcol;                          // column of this beat
   logic       fill_ib, fill_rb;              // beat lands in a buffer
   assign fcol    = pend_q.addr[4:3] + beat_q;
   assign fill_ib = state_q == DBU_S_RDAT && mem_rvalid && p_burst_q && !p_tgt_rb_q;
   assign fill_rb = state_q == DBU_S_RDAT && mem_rvalid && p_burst_q && p_tgt_rb_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ib_tag_q   <= 27'h0;
         ib_valid_q <= 4'h0;
      end else if (mem_exc) begin
         ib_valid_q <= 4'h0; // RULE5
      end else if (take && req.kind == DBU_FLUSH) begin
         ib_valid_q <= 4'h0; // RULE8
      end else if (take && (req.kind == DBU_ATOMIC || (is_ibk && !cach)) && ib_tag_q == rtag) begin
         ib_valid_q <= 4'h0; // RULE4 RULE7
      end else if (state_q == DBU_S_RD && p_burst_q && !p_tgt_rb_q) begin
         ib_tag_q   <= pend_q.addr[31:5];
         ib_valid_q <= 4'h0;
      end else if (fill_ib) begin
         ib_valid_q[fcol] <= 1'b1; // RULE1
      end
   end
   // prefetch data columns
   always_ff @(posedge ref_clk) begin
      if (fill_ib) begin
         ib_data_q[fcol] <= mem_rdata;
      end
   end
   // ===========================================
   // line buffers and replacement order
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rb_tag_q[0] <= 27'h0;
         rb_tag_q[1] <= 27'h0;
         rb_valid_q  <= 2'h0;
         lru_q       <= 1'b0;
      end else if (take && (req.kind == DBU_ATOMIC || (!is_ibk && req.kind == DBU_LOAD && !cach))) begin
         rb_valid_q <= rb_valid_q & ~rb_hit; // RULE13 RULE19
      end else if (take && req.kind == DBU_LOAD && cach && !is_ibk && |rb_hit) begin
         lru_q <= ~rb_hit[1]; // RULE10
      end else if (state_q == DBU_S_RD && p_burst_q && p_tgt_rb_q) begin
         rb_tag_q[p_sel_q]   <= pend_q.addr[31:5];
         rb_valid_q[p_sel_q] <= 1'b1; // RULE12
         lru_q               <= ~p_sel_q;
      end
   end
   // line data: fills, and cached stores keep a hitting line current
   always_ff @(posedge ref_clk) begin
      if (fill_rb) begin
         rb_data_q[p_sel_q][fcol] <= mem_rdata;
      end else if (take && req.kind == DBU_STORE && cach && !is_ibk) begin
         for (int j = 0; j < 2; j++) begin
            for (int b = 0; b < 8; b++) begin
               if (rb_hit[j] && req.be[b]) begin
                  rb_data_q[j][rcol][b*8 +: 8] <= req.wdata[b*8 +: 8]; // RULE22
               end
            end
         end
      end
   end
   // ===========================================
   // store fifo
   logic push, pop;                           // enqueue / dequeue
   assign push = take && req.kind inside {DBU_STORE} && !merge;
   assign pop  = mem_req && mem_gnt && mem_cmd.we && state_q == DBU_S_DRAIN;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wr_ptr_q <= 4'h0;
         rd_ptr_q <= 4'h0;
         cnt_q    <= 5'h0;
         sf_occ_q <= '0;
      end else begin
         if (push) begin
            sf_occ_q[wr_ptr_q] <= 1'b1;
            wr_ptr_q <= (wr_ptr_q == depth) ? 4'h0 : wr_ptr_q + 4'h1; // RULE15
         end
         if (pop) begin
            sf_occ_q[rd_ptr_q] <= 1'b0;
            rd_ptr_q <= (rd_ptr_q == depth) ? 4'h0 : rd_ptr_q + 4'h1;
         end
         cnt_q <= cnt_q + 5'(push) - 5'(pop);
      end
   end
   // fifo payload: new entry, or merge of bytes into the newest
   always_ff @(posedge ref_clk) begin
      if (push) begin
         sf_addr_q[wr_ptr_q] <= req.addr[31:3];
         sf_data_q[wr_ptr_q] <= req.wdata;
         sf_be_q[wr_ptr_q]   <= req.be; // RULE17
      end else if (take && req.kind == DBU_STORE && merge) begin
         sf_be_q[last] <= sf_be_q[last] | req.be;
         for (int b = 0; b < 8; b++) begin
            if (req.be[b]) begin
               sf_data_q[last][b*8 +: 8] <= req.wdata[b*8 +: 8]; // RULE16
            end
         end
      end
   end
   // ===========================================
   // register port
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_q    <= `DBU_CTRL_RESET;
         reg_rdata <= 32'h0;
      end else begin
         if (reg_wr && reg_addr == `DBU_REG_CTRL) begin
            ctrl_q <= reg_wdata[1:0];
         end
         reg_rdata <= 32'h0;
         if (reg_rd && reg_addr == `DBU_REG_CTRL) begin
            reg_rdata <= {30'h0, ctrl_q};
         end else if (reg_rd && reg_addr == `DBU_REG_STATUS) begin
            reg_rdata <= {20'h0, state_q != DBU_S_IDLE, rb_valid_q, ib_valid_q, cnt_q};
         end
      end
   end
   // ===========================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_ib_hit_take;
      take && req.kind == DBU_FETCH && cach && is_ibk && ib_hit;
   endsequence
   property p_ib_hit;
      s_ib_hit_take |=> rsp_valid && !mem_req && state_q == DBU_S_IDLE;
   endproperty
   a_ib_hit: assert property (p_ib_hit) else $error("prefetch hit not answered"); // RULE3
   property p_memory_exception;
      mem_exc |=> ib_valid_q == 4'h0;
   endproperty
   a_memory_exception: assert property (p_memory_exception) else $error("exception left prefetch valid"); // RULE5
   property p_flush;
      take && req.kind == DBU_FLUSH |=> ib_valid_q == 4'h0 && rsp_valid;
   endproperty
   a_flush: assert property (p_flush) else $error("flush left prefetch valid"); // RULE8
   property p_single_wr;
      mem_req && mem_cmd.we |-> !mem_cmd.burst;
   endproperty
   a_single_wr: assert property (p_single_wr) else $error("burst write seen"); // RULE15
   property p_be;
      pop |-> mem_cmd.be == sf_be_q[rd_ptr_q] && mem_cmd.addr[31:3] == sf_addr_q[rd_ptr_q];
   endproperty
   a_be: assert property (p_be) else $error("byte enables differ from entry"); // RULE17
   property p_atomic_drained;
      state_q == DBU_S_AWR |-> cnt_q == 5'h0;
   endproperty
   a_atomic_drained: assert property (p_atomic_drained) else $error("atomic store before drain"); // RULE19
   property p_nc_inval;
      take && req.kind == DBU_LOAD && !cach && !is_ibk && rb_hit[0] |=> !rb_valid_q[0];
   endproperty
   a_nc_inval: assert property (p_nc_inval) else $error("uncached load kept line"); // RULE13
   property p_merge;
      take && req.kind == DBU_STORE && merge |=> $stable(cnt_q) && $stable(wr_ptr_q);
   endproperty
   a_merge: assert property (p_merge) else $error("merge queued new entry"); // RULE16
   sequence s_first_beat;
      state_q == DBU_S_RDAT && mem_rvalid && beat_q == 2'h0;
   endsequence
   property p_fwd;
      s_first_beat |=> rsp_valid ##1 !(rsp_valid && p_burst_q);
   endproperty
   a_fwd: assert property (p_fwd) else $error("first beat not forwarded"); // RULE12
endmodule

// [dv/dbu_mem_model.sv]
// Purpose: memory side partner of the data buffer unit
// Assumes: one command outstanding; beats wrap from the requested column
// Notes:   slow inserts a gap after every beat; idle read data toggles
`timescale 1ns/1ps
module dbu_mem_model (
   input  wire logic              ref_clk, // clock
   input  wire logic              slow,    // gapped beats
   input  wire dbu_pkg::dbu_mem_t mem_cmd, // command
   input  wire logic              mem_req, // command valid
   output logic                   mem_gnt,    // accept
   output logic                   mem_rvalid, // beat
   output logic [63:0]            mem_rdata   // beat data
);
   import dbu_pkg::*;
   logic [2:0]  left_q = 3'h0; // beats still owed
   logic [31:0] a_q = 32'h0;   // next beat address
   logic        tick_q = 1'b0; // gap phase
   initial {mem_gnt, mem_rvalid, mem_rdata} = '0;
   // grant one command at a time, then return its beats
   always @(posedge ref_clk) begin
      tick_q <= ~tick_q;
      mem_gnt <= mem_req && !mem_gnt && left_q == 3'h0;
      if (mem_req && mem_gnt && !mem_cmd.we) begin
         left_q <= mem_cmd.burst ? 3'h4 : 3'h1;
         a_q <= mem_cmd.addr;
      end
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata; // no stale data between beats
      if (left_q != 3'h0 && !(slow && tick_q)) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= {a_q, ~a_q};
         a_q[4:3] <= a_q[4:3] + 2'h1; // wrap inside the line
         left_q <= left_q - 3'h1;
      end
   end
endmodule

// [dv/tb_top.sv]
// Purpose: self-checking bench of the data buffer unit
// Assumes: dbu_mem_model answers every memory command
// Notes:   granted memory commands are logged and checked in order
`timescale 1ns/1ps
`include "dbu_cfg.svh"
module tb_top;
   import dbu_pkg::*;
   // ===========================================
   // signals
   logic        ref_clk, rstn, req_valid, req_ready, rsp_valid, mem_exc, mem_req, mem_gnt, mem_rvalid;
   logic        reg_wr, reg_rd, slow;
   logic [63:0] rsp_data, mem_rdata, d;
   logic [31:0] reg_wdata, reg_rdata, r;
   logic [7:0]  reg_addr;
   dbu_req_t    req;
   dbu_mem_t    mem_cmd;
   dbu_mem_t    log[$]; // granted commands
   int          error_cnt = 0, n_tests = 0, cyc = 0;
   dbu_data_buffer_unit uut (.*);
   dbu_mem_model mem (.*);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // log grants as the unit sees them; cut a hang short
   always @(posedge ref_clk) begin
      if (mem_req === 1'b1 && mem_gnt === 1'b1) log.push_back(mem_cmd);
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // ===========================================
   // helpers
   function automatic logic [63:0] md(logic [31:0] a); // model data
      return {a, ~a};
   endfunction
   function automatic dbu_req_t q(dbu_kind_t k, logic [3:0] s, logic n, logic [31:0] a,
                                  logic [7:0] b = 8'hff, logic [63:0] w = 64'h0);
      return '{k, s, n, a, b, w};
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic lchk(input int k, input logic w, input logic b, input logic [31:0] a);
      chk(64'({log[k].we, log[k].burst, log[k].addr}), 64'({w, b, a}));
   endtask
   task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'b00;
      @(negedge ref_clk);
      r = reg_rdata;
   endtask
   // hold a request until it is taken
   task automatic put(input dbu_req_t x);
      int i = 0;
      {req, req_valid} <= {x, 1'b1};
      do @(negedge ref_clk); while (req_ready !== 1'b1 && ++i < 300);
      @(posedge ref_clk);
   endtask
   // one request, or two back to back, then the last answer
   task automatic run(input dbu_req_t x, input dbu_req_t y = '0, input bit two = 1'b0);
      int i = 0;
      @(posedge ref_clk);
      put(x);
      if (two) put(y);
      req_valid <= 1'b0;
      do @(negedge ref_clk); while (rsp_valid !== 1'b1 && ++i < 300);
      d = rsp_data;
   endtask
   task automatic ld(input dbu_kind_t k, input logic [3:0] s, input logic n, input logic [31:0] a, input int c);
      run(q(k, s, n, a));
      chk(d, md(a));
      chk(64'(log.size()), 64'(c));
   endtask
   // ===========================================
   // scenarios
   task automatic t_fetch();
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h108, 1);
      lchk(0, 1'b0, 1'b1, 32'h108);
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h110, 1);
      @(posedge ref_clk) mem_exc <= 1'b1;
      @(posedge ref_clk) mem_exc <= 1'b0;
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h100, 2);
      run(q(DBU_FLUSH, 4'h8, 1'b0, 32'h0));
      ld(DBU_FETCH, 4'h9, 1'b0, 32'h118, 3);
      ld(DBU_FETCH, 4'h9, 1'b1, 32'h118, 4);
      lchk(3, 1'b0, 1'b0, 32'h118);
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h118, 5);
      ld(DBU_LOAD, 4'h9, 1'b0, 32'h140, 6);
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h158, 6);
      ld(DBU_ATOMIC, 4'h8, 1'b0, 32'h150, 7);
      ld(DBU_FETCH, 4'h8, 1'b0, 32'h158, 9);
   endtask
   task automatic t_load();
      log.delete();
      slow <= 1'b1;
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h200, 1);
      lchk(0, 1'b0, 1'b1, 32'h200);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h218, 1);
      ld(DBU_LOAD, 4'hb, 1'b0, 32'h400, 2);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h208, 2);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h600, 3);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h200, 3);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h400, 4);
      ld(DBU_LOAD, 4'ha, 1'b1, 32'h200, 5);
      ld(DBU_LOAD, 4'ha, 1'b0, 32'h200, 6);
      slow <= 1'b0;
   endtask
   task automatic t_store();
      for (int m = 1; m >= 0; m--) begin
         reg_op(1'b1, `DBU_REG_CTRL, 32'(m));
         log.delete();
         run(q(DBU_STORE, 4'ha, 1'b0, 32'h300, 8'h01, 64'h11),
             q(DBU_STORE, 4'ha, 1'b0, 32'h300, 8'h02, 64'h2200), 1'b1);
         for (int i = 0; i < 60 && log.size() < 2; i++) @(negedge ref_clk);
         chk(64'(log.size()), 64'(2 - m));
         lchk(0, 1'b1, 1'b0, 32'h300);
         chk(log[0].be, m ? 8'h03 : 8'h01);
         chk(log[0].wdata[15:0] & {m ? 8'hff : 8'h00, 8'hff}, m ? 16'h2211 : 16'h0011);
      end
   endtask
   task automatic t_atomic();
      log.delete();
      run(q(DBU_STORE, 4'ha, 1'b0, 32'h700), q(DBU_ATOMIC, 4'ha, 1'b0, 32'h800), 1'b1);
      chk(d, md(32'h800));
      lchk(0, 1'b1, 1'b0, 32'h700);
      lchk(1, 1'b0, 1'b0, 32'h800);
      run(q(DBU_STORE, 4'ha, 1'b0, 32'h900), q(DBU_LOAD, 4'ha, 1'b0, 32'h900), 1'b1);
      lchk(2, 1'b1, 1'b0, 32'h800);
      lchk(3, 1'b1, 1'b0, 32'h900);
      lchk(4, 1'b0, 1'b1, 32'h900);
      run(q(DBU_STORE, 4'ha, 1'b0, 32'h208, 8'hff, 64'h5), q(DBU_LOAD, 4'ha, 1'b0, 32'h208), 1'b1);
      chk(d, 64'h5);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // reset, registers, then the scenarios
   initial begin
      {rstn, req, req_valid, mem_exc, reg_addr, reg_wdata, reg_wr, reg_rd, slow} = '0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      reg_op(1'b0, `DBU_REG_CTRL, 32'h0);
      chk(r, 32'h1);
      reg_op(1'b0, 8'h10, 32'h0);
      chk(r, 32'h0);
      t_fetch();
      t_load();
      t_store();
      t_atomic();
      summarize();
   end
endmodule
